// *** dma_master.sv ***
// file: dma master model standing on the target side of the pod
module dma_master (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic grant_i,
  output logic req_o,
  output logic gack_o,
  output logic strobe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================================
  // request, wait for grant (bounded), own bus four cycles
  initial begin
    req_o = 1'b0;
    gack_o = 1'b0;
    strobe_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (start_i === 1'b1) begin
        req_o <= 1'b1;
        for (int i = 0; i < 20 && grant_i !== 1'b1; i++) @(posedge clk_i);
        if (grant_i === 1'b1) begin
          gack_o <= 1'b1;
          strobe_o <= 1'b1;
          repeat (4) @(posedge clk_i);
        end
        // release after the four owned cycles, or on no grant give up rather than hang the bus
        req_o <= 1'b0;
        gack_o <= 1'b0;
        strobe_o <= 1'b0;
      end
    end
  end
endmodule : dma_master

// *** pin_sync.sv ***
// file: two-flop synchroniser for a vector of pin inputs
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] q;
  // ==========================================================
  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    if (!nrst_i) begin
      q <= rst_val_i; // caller picks the idle level of each pin
    end else begin
      q <= meta;
    end
  end
  assign q_o = q;
endmodule : pin_sync

// *** pod_bus_gating.sv ***
// file: emulator pod bus gating top module
module pod_bus_gating #(
  parameter int IPL_W = pod_gating_pkg::IPL_W,
  parameter int TRAP_W = pod_gating_pkg::TRAP_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  // host configuration port
  input wire logic cfg_we_i,
  input wire logic running_i,
  input wire logic ack_interlock_i,
  input wire logic bus_error_in_on_emul_i,
  input wire logic int_enable_i,
  input wire logic dma_enable_i,
  input wire logic dma_to_emul_i,
  input wire logic trace_dma_i,
  input wire logic trace_tags_i,
  input wire logic lvl7_use_i,
  input wire logic lvl7_share_i,
  input wire logic halt_delay_i,
  input wire logic [TRAP_W-1:0] trap_sel_i,
  input wire logic host_access_i,
  // processor side
  input wire logic emul_cycle_i,
  input wire logic internal_ack_i,
  input wire logic bus_grant_out_i,
  // target pins
  input wire logic transfer_ack_i,
  input wire logic bus_error_in_i,
  input wire logic [IPL_W-1:0] ipl_i,
  input wire logic bus_request_in_i,
  input wire logic bus_grant_ack_in_i,
  input wire logic addr_strobe_i,
  input wire logic upper_byte_strobe_i,
  input wire logic lower_byte_strobe_i,
  // outputs
  output logic cpu_transfer_ack_o,
  output logic cpu_bus_error_o,
  output logic [IPL_W-1:0] cpu_ipl_o,
  output logic cpu_bus_request_o,
  output logic cpu_bus_grant_ack_o,
  output logic bus_grant_out_o,
  output logic emul_dma_sel_o,
  output logic trace_store_o,
  output logic [TRAP_W-1:0] trap_sel_o,
  output logic lvl7_use_o,
  output logic lvl7_share_o,
  output logic halt_delay_o
);
  localparam int PW = IPL_W + 6;
  // ==========================================================
  // pin synchronisers
  logic [PW-1:0] pins_raw;
  logic [PW-1:0] pins;
  logic t_ack;
  logic t_bus_error_in;
  logic [IPL_W-1:0] t_ipl;
  logic t_breq;
  logic t_bus_grant_ack_in;
  logic t_as;
  logic t_ds;
  assign pins_raw = {transfer_ack_i, bus_error_in_i, ipl_i, bus_request_in_i,
    bus_grant_ack_in_i, addr_strobe_i,
    upper_byte_strobe_i | lower_byte_strobe_i};
  pin_sync #(.W(PW)) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(pins_raw),
    .rst_val_i('0),
    .q_o(pins)
  );
  assign {t_ack, t_bus_error_in, t_ipl, t_breq, t_bus_grant_ack_in, t_as, t_ds} = pins;

  // ==========================================================
  // configuration bits
  logic ack_interlock, next_ack_interlock;
  logic bus_error_in_on_emul, next_bus_error_in_on_emul;
  logic int_enable, next_int_enable;
  logic dma_enable, next_dma_enable;
  logic dma_to_emul, next_dma_to_emul;
  logic trace_dma, next_trace_dma;
  logic trace_tags, next_trace_tags;
  logic [TRAP_W-1:0] trap_sel, next_trap_sel;
  logic lvl7_use, next_lvl7_use;
  logic lvl7_share, next_lvl7_share;
  logic halt_delay, next_halt_delay;
  logic cfg_load;

  // writes during a run are dropped so gating stays stable
  assign cfg_load = cfg_we_i && !running_i;
  always_comb begin
    next_ack_interlock = ack_interlock;
    next_bus_error_in_on_emul = bus_error_in_on_emul;
    next_int_enable = int_enable;
    next_dma_enable = dma_enable;
    next_dma_to_emul = dma_to_emul;
    next_trace_dma = trace_dma;
    next_trace_tags = trace_tags;
    next_trap_sel = trap_sel;
    next_lvl7_use = lvl7_use;
    next_lvl7_share = lvl7_share;
    next_halt_delay = halt_delay;
    if (cfg_load) begin
      next_ack_interlock = ack_interlock_i;
      next_bus_error_in_on_emul = bus_error_in_on_emul_i;
      next_int_enable = int_enable_i;
      next_dma_enable = dma_enable_i;
      next_dma_to_emul = dma_to_emul_i;
      next_trace_dma = trace_dma_i;
      next_trace_tags = trace_tags_i;
      next_trap_sel = trap_sel_i;
      next_lvl7_use = lvl7_use_i;
      next_lvl7_share = lvl7_share_i;
      next_halt_delay = halt_delay_i;
    end
  end

  // defaults on reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ack_interlock <= pod_gating_pkg::ACK_INTERLOCK_RST;
      bus_error_in_on_emul <= pod_gating_pkg::BUS_ERROR_IN_ON_EMUL_RST;
      int_enable <= pod_gating_pkg::INT_ENABLE_RST;
      dma_enable <= pod_gating_pkg::DMA_ENABLE_RST;
      dma_to_emul <= pod_gating_pkg::DMA_TO_EMUL_RST;
      trace_dma <= pod_gating_pkg::TRACE_DMA_RST;
      trace_tags <= pod_gating_pkg::TRACE_TAGS_RST;
      trap_sel <= pod_gating_pkg::TRAP_SEL_RST;
      lvl7_use <= pod_gating_pkg::LVL7_USE_RST;
      lvl7_share <= pod_gating_pkg::LVL7_SHARE_RST;
      halt_delay <= pod_gating_pkg::HALT_DELAY_RST;
    end else begin
      ack_interlock <= next_ack_interlock;
      bus_error_in_on_emul <= next_bus_error_in_on_emul;
      int_enable <= next_int_enable;
      dma_enable <= next_dma_enable;
      dma_to_emul <= next_dma_to_emul;
      trace_dma <= next_trace_dma;
      trace_tags <= next_trace_tags;
      trap_sel <= next_trap_sel;
      lvl7_use <= next_lvl7_use;
      lvl7_share <= next_lvl7_share;
      halt_delay <= next_halt_delay;
    end
  end

  // ==========================================================
  // dma handshake tracker, one tag per completed request/grant
  pod_gating_pkg::hs_state_e hs, next_hs;
  logic hs_tag;
  logic dma_owned;
  always_comb begin
    next_hs = hs;
    hs_tag = 1'b0;
    case (hs)
      pod_gating_pkg::HS_IDLE: begin
        if (cpu_bus_request_o) begin
          next_hs = pod_gating_pkg::HS_REQ;
        end
      end
      pod_gating_pkg::HS_REQ: begin
        if (cpu_bus_grant_ack_o) begin
          next_hs = pod_gating_pkg::HS_OWN;
          hs_tag = 1'b1;
        end else if (!cpu_bus_request_o) begin
          next_hs = pod_gating_pkg::HS_IDLE;
        end
      end
      pod_gating_pkg::HS_OWN: begin
        if (!cpu_bus_grant_ack_o) begin
          next_hs = pod_gating_pkg::HS_IDLE;
        end
      end
      default: next_hs = pod_gating_pkg::HS_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hs <= pod_gating_pkg::HS_IDLE;
    end else begin
      hs <= next_hs;
    end
  end
  assign dma_owned = (hs == pod_gating_pkg::HS_OWN);

  // ==========================================================
  // gated outputs, all registered
  logic next_ack, next_bus_error_in, next_breq, next_bus_grant_ack_in, next_sel, next_trace;
  logic [IPL_W-1:0] next_ipl;
  logic dma_gate;
  // host access overrides the dma enable entirely
  assign dma_gate = dma_enable && !host_access_i;
  always_comb begin
    // interlock is an AND; without it only the internal ack is passed on emulation cycles
    if (!emul_cycle_i) begin
      next_ack = t_ack;
    end else if (ack_interlock) begin
      next_ack = t_ack && internal_ack_i;
    end else begin
      next_ack = internal_ack_i;
    end
    next_bus_error_in = t_bus_error_in && (!emul_cycle_i || bus_error_in_on_emul);
    next_ipl = int_enable ? t_ipl : pod_gating_pkg::IPL_NONE;
    next_breq = t_breq && dma_gate;
    next_bus_grant_ack_in = t_bus_grant_ack_in && dma_gate;
    // emulation memory answers a dma master only when allowed
    next_sel = dma_owned && dma_to_emul && t_as && t_ds;
    next_trace = (trace_dma && dma_owned && t_as && t_ds)
      || (trace_tags && hs_tag);
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cpu_transfer_ack_o <= 1'b0;
      cpu_bus_error_o <= 1'b0;
      cpu_ipl_o <= pod_gating_pkg::IPL_NONE;
      cpu_bus_request_o <= 1'b0;
      cpu_bus_grant_ack_o <= 1'b0;
      bus_grant_out_o <= 1'b0;
      emul_dma_sel_o <= 1'b0;
      trace_store_o <= 1'b0;
    end else begin
      cpu_transfer_ack_o <= next_ack;
      cpu_bus_error_o <= next_bus_error_in;
      cpu_ipl_o <= next_ipl;
      cpu_bus_request_o <= next_breq;
      cpu_bus_grant_ack_o <= next_bus_grant_ack_in;
      bus_grant_out_o <= bus_grant_out_i && dma_gate;
      emul_dma_sel_o <= next_sel;
      trace_store_o <= next_trace;
    end
  end
  assign trap_sel_o = trap_sel;
  assign lvl7_use_o = lvl7_use;
  assign lvl7_share_o = lvl7_share;
  assign halt_delay_o = halt_delay;

  // ==========================================================
  // checks
  chk_int_mask: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !int_enable |=> cpu_ipl_o == pod_gating_pkg::IPL_NONE)
    else $error("interrupt level passed while masked");
  chk_dma_block: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !dma_gate |=> !cpu_bus_request_o && !bus_grant_out_o)
    else $error("dma request passed while blocked");
  chk_emul_ack: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    emul_cycle_i && ack_interlock && !t_ack |=> !cpu_transfer_ack_o)
    else $error("interlocked ack without target ack");
  chk_emul_bus_error_in: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    emul_cycle_i && !bus_error_in_on_emul |=> !cpu_bus_error_o)
    else $error("bus error passed on emulation cycle");
  chk_emul_dma: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !dma_to_emul |=> !emul_dma_sel_o)
    else $error("dma reached emulation memory while off");
  chk_trace_off: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !trace_dma && !trace_tags |=> !trace_store_o)
    else $error("trace stored while disabled");
  // grant ack while a request is pending completes one handshake
  sequence seq_grant_seen;
    hs == pod_gating_pkg::HS_REQ && cpu_bus_grant_ack_o;
  endsequence
  chk_tag_store: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    trace_tags ##0 seq_grant_seen |=> trace_store_o)
    else $error("handshake tag not stored");
  chk_cfg_stable: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    running_i |=> $stable(trap_sel_o))
    else $error("trap selector changed during run");
endmodule : pod_bus_gating

// *** pod_gating_pkg.sv ***
// package: constants for the emulator pod bus gating block
package pod_gating_pkg;
  // ==========================================================
  // configuration reset values
  localparam logic ACK_INTERLOCK_RST = 1'b0;
  localparam logic BUS_ERROR_IN_ON_EMUL_RST = 1'b0;
  localparam logic INT_ENABLE_RST = 1'b1;
  localparam logic DMA_ENABLE_RST = 1'b1;
  localparam logic DMA_TO_EMUL_RST = 1'b0;
  localparam logic TRACE_DMA_RST = 1'b0;
  localparam logic TRACE_TAGS_RST = 1'b0;
  localparam logic LVL7_USE_RST = 1'b1;
  localparam logic LVL7_SHARE_RST = 1'b1;
  localparam logic HALT_DELAY_RST = 1'b0;
  localparam int TRAP_W = 4;
  localparam logic [TRAP_W-1:0] TRAP_SEL_RST = 4'hf;
  localparam int IPL_W = 3;
  localparam logic [IPL_W-1:0] IPL_NONE = 3'h0;
  // ==========================================================
  // handshake tracker states
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_REQ = 3'b010,
    HS_OWN = 3'b100
  } hs_state_e;
endpackage : pod_gating_pkg

// *** tb_top.sv ***
// file: self-checking testbench for the pod bus gating block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0;
  logic nrst_i = 0;
  logic we = 0;
  logic run = 0;
  logic host = 0;
  logic start = 0;
  logic [9:0] opt = 10'h0c6;
  logic [3:0] trap = 4'hf;
  logic [3:0] pin = 4'h0;
  logic [2:0] ipl = 3'h0;
  logic req, gack, stb, gnt, ack, bus_error_in, cbr, grant, esel, store, cbga;
  logic [2:0] cipl;
  logic [3:0] tsel;
  logic l7u, l7s, hdl;
  int fails = 0;
  int check_count = 0;
  int gcnt, scnt, ecnt, acnt;
  dma_master far (.clk_i(clk_i), .start_i(start), .grant_i(grant),
    .req_o(req), .gack_o(gack), .strobe_o(stb));
  pod_bus_gating dut (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_we_i(we),
    .running_i(run), .ack_interlock_i(opt[9]), .bus_error_in_on_emul_i(opt[8]),
    .int_enable_i(opt[7]), .dma_enable_i(opt[6]), .dma_to_emul_i(opt[5]),
    .trace_dma_i(opt[4]), .trace_tags_i(opt[3]), .lvl7_use_i(opt[2]),
    .lvl7_share_i(opt[1]), .halt_delay_i(opt[0]), .trap_sel_i(trap),
    .host_access_i(host), .emul_cycle_i(pin[3]), .internal_ack_i(pin[1]),
    .bus_grant_out_i(gnt), .transfer_ack_i(pin[2]), .bus_error_in_i(pin[0]),
    .ipl_i(ipl), .bus_request_in_i(req), .bus_grant_ack_in_i(gack),
    .addr_strobe_i(stb), .upper_byte_strobe_i(stb),
    .lower_byte_strobe_i(stb), .cpu_transfer_ack_o(ack),
    .cpu_bus_error_o(bus_error_in), .cpu_ipl_o(cipl), .cpu_bus_request_o(cbr),
    .cpu_bus_grant_ack_o(cbga), .bus_grant_out_o(grant),
    .emul_dma_sel_o(esel), .trace_store_o(store), .trap_sel_o(tsel),
    .lvl7_use_o(l7u), .lvl7_share_o(l7s), .halt_delay_o(hdl));
  // ====================================================
  // clock, processor grant loopback and activity counters
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    gnt <= (cbr === 1'b1);
    gcnt += (grant === 1'b1);
    scnt += (store === 1'b1);
    ecnt += (esel === 1'b1);
    acnt += (cbga === 1'b1);
  end
  // ====================================================
  // tasks
  // wide enough for the five-bit option and selector pairs
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      fails++;
    end
  endtask : chk
  task cfg(input logic [9:0] o, input logic [3:0] t);
    @(posedge clk_i);
    opt <= o;
    trap <= t;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : cfg
  // settle: 2 sync flops plus output register, with margin
  task settle();
    repeat (5) @(posedge clk_i);
    #1;
  endtask : settle
  task dma(input logic [9:0] o);
    cfg(o, 4'hf);
    gcnt = 0;
    scnt = 0;
    ecnt = 0;
    acnt = 0;
    @(posedge clk_i);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    repeat (40) @(posedge clk_i);
    #1;
  endtask : dma
  task conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  // ====================================================
  // watchdog: the tests need well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    conclude();
  end
  // ====================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    settle();
    chk(tsel, 4'hf);
    chk({l7u, l7s, hdl}, 3'h6);
    cfg(10'h0c7, 4'h5);
    chk({hdl, tsel}, 5'h15);
    @(posedge clk_i);
    run <= 1'b1;
    cfg(10'h0c6, 4'h3);
    chk({hdl, tsel}, 5'h15);
    @(posedge clk_i);
    run <= 1'b0;
    // emulation bit, target ack, internal ack, bus error in
    for (int k = 0; k < 32; k++) begin
      if (k[3:0] == 0) cfg(k[4] ? 10'h3c6 : 10'h0c6, 4'hf);
      @(posedge clk_i);
      pin <= k[3:0];
      settle();
      chk(ack, k[3] ? (k[4] ? k[2] & k[1] : k[1]) : k[2]);
      chk(bus_error_in, k[3] ? k[4] & k[0] : k[0]);
    end
    @(posedge clk_i);
    ipl <= 3'h5;
    cfg(10'h0c6, 4'hf);
    settle();
    chk(cipl, 3'h5);
    cfg(10'h046, 4'hf);
    settle();
    chk(cipl, 3'h0);
    dma(10'h086);
    chk(gcnt != 0, 1'b0);
    chk(acnt != 0, 1'b0);
    dma(10'h0ce);
    chk({gcnt != 0, scnt == 1, ecnt != 0}, 3'h6);
    // master owns the bus four cycles, so four grant ack cycles pass
    chk(acnt == 4, 1'b1);
    dma(10'h0f6);
    chk({ecnt != 0, scnt != 0}, 2'h3);
    @(posedge clk_i);
    host <= 1'b1;
    dma(10'h0c6);
    chk(gcnt != 0, 1'b0);
    conclude();
  end
endmodule : tb_top
